//--- osr_top.sv
`timescale 1ns/1ps
module osr_top #(
  parameter int HOLD_CYCLES = osr_pkg::MODE_HOLD_CYCLES // mode key hold time in cycles
) (
  input wire logic ref_clk_i,           // system clock, 50 MHz
  input wire logic sys_rst_i,           // sync reset, active high
  input wire logic servo_on_i,          // motor energized
  input wire logic [8:0] status_flags_i, // internal drive status signals
  input wire logic [1:0] param_sel_i,   // parameter being addressed
  input wire logic edit_open_i,         // pulse: enter edit of selected parameter
  input wire logic edit_write_i,        // pulse: load edit_data_i into edit value
  input wire logic [15:0] edit_data_i,  // new edit value
  input wire logic save_i,              // pulse: commit edit value
  input wire logic mode_key_i,          // mode key pin, high while pressed
  input wire logic view_sel_i,          // output status view selected
  output logic [4:0] contact_o,         // output contacts one to five
  output logic [4:0] status_led_o,      // leds, bit 0 is rightmost position
  output logic [8:0] always_alloc_o,    // signals marked always allocated
  output logic editing_o,               // edit in progress
  output logic [15:0] edit_value_o,     // value being edited
  output logic [1:0] edit_sel_o,        // parameter being edited
  output logic [15:0] param_rdata_o,    // stored value of param_sel_i
  output logic saved_o,                 // pulse: save accepted
  output logic refused_o                // pulse: save refused, servo on
);

  typedef enum logic {OSR_IDLE, OSR_EDIT} osr_state_e;

  osr_route_if rt ();

  // ----------------------------------------------------------------
  // mode key synchroniser
  // ----------------------------------------------------------------
  logic key_s1_reg, key_s2_reg, key_s3_reg, key_lvl_reg;
  logic key_lvl_next;

  always_comb
  begin
    key_lvl_next = key_lvl_reg;
    if (key_s2_reg == key_s3_reg)
      key_lvl_next = key_s3_reg;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      key_s1_reg <= 1'b0;
      key_s2_reg <= 1'b0;
      key_s3_reg <= 1'b0;
      key_lvl_reg <= 1'b0;
    end
    else
    begin
      key_s1_reg <= mode_key_i;
      key_s2_reg <= key_s1_reg;
      key_s3_reg <= key_s2_reg;
      key_lvl_reg <= key_lvl_next;
    end
  end

  // ----------------------------------------------------------------
  // parameter store and edit sequence
  // ----------------------------------------------------------------
  osr_state_e state_reg, state_next;
  logic [15:0] group_a_reg, group_a_next;
  logic [15:0] group_b_reg, group_b_next;
  logic [15:0] group_c_reg, group_c_next;
  logic [15:0] pol_reg, pol_next;
  logic [15:0] edit_reg, edit_next;
  logic [1:0] sel_reg, sel_next;
  logic [25:0] hold_reg, hold_next;
  logic saved_next, refused_next, saved_reg, refused_reg;
  logic [15:0] rdata_reg, rdata_next;
  logic hold_done;

  // full hold reached on this cycle
  assign hold_done = key_lvl_reg && hold_reg == 26'(HOLD_CYCLES - 1);

  always_comb
  begin
    state_next = state_reg;
    group_a_next = group_a_reg;
    group_b_next = group_b_reg;
    group_c_next = group_c_reg;
    pol_next = pol_reg;
    edit_next = edit_reg;
    sel_next = sel_reg;
    hold_next = 26'h0000000;
    saved_next = 1'b0;
    refused_next = 1'b0;
    case (state_reg)
      OSR_IDLE:
      begin
        if (edit_open_i)
        begin
          state_next = OSR_EDIT;
          sel_next = param_sel_i;
          case (param_sel_i)
            osr_pkg::SEL_GROUP_A: edit_next = group_a_reg;
            osr_pkg::SEL_GROUP_B: edit_next = group_b_reg;
            osr_pkg::SEL_GROUP_C: edit_next = group_c_reg;
            default: edit_next = pol_reg;
          endcase
        end
      end
      OSR_EDIT:
      begin
        if (key_lvl_reg)
          hold_next = hold_reg + 26'h0000001;
        if (hold_done)
        begin
          // edited value simply dropped, store untouched
          state_next = OSR_IDLE;
          hold_next = 26'h0000000;
        end
        else if (save_i && servo_on_i)
          refused_next = 1'b1;
        else if (save_i)
        begin
          state_next = OSR_IDLE;
          saved_next = 1'b1;
          case (sel_reg)
            osr_pkg::SEL_GROUP_A: group_a_next = edit_reg;
            osr_pkg::SEL_GROUP_B: group_b_next = edit_reg;
            osr_pkg::SEL_GROUP_C: group_c_next = edit_reg;
            default: pol_next = edit_reg;
          endcase
        end
        else if (edit_write_i)
          edit_next = edit_data_i;
      end
      default: state_next = OSR_IDLE;
    endcase
    case (param_sel_i)
      osr_pkg::SEL_GROUP_A: rdata_next = group_a_reg;
      osr_pkg::SEL_GROUP_B: rdata_next = group_b_reg;
      osr_pkg::SEL_GROUP_C: rdata_next = group_c_reg;
      default: rdata_next = pol_reg;
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      state_reg <= OSR_IDLE;
      group_a_reg <= osr_pkg::GROUP_A_RESET;
      group_b_reg <= osr_pkg::GROUP_B_RESET;
      group_c_reg <= osr_pkg::GROUP_C_RESET;
      pol_reg <= osr_pkg::POLARITY_RESET;
      edit_reg <= 16'h0000;
      sel_reg <= 2'h0;
      hold_reg <= 26'h0000000;
      saved_reg <= 1'b0;
      refused_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end
    else
    begin
      state_reg <= state_next;
      group_a_reg <= group_a_next;
      group_b_reg <= group_b_next;
      group_c_reg <= group_c_next;
      pol_reg <= pol_next;
      edit_reg <= edit_next;
      sel_reg <= sel_next;
      hold_reg <= hold_next;
      saved_reg <= saved_next;
      refused_reg <= refused_next;
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // routing and status view
  // ----------------------------------------------------------------
  assign rt.alloc_a = group_a_reg;
  assign rt.alloc_b = group_b_reg;
  assign rt.alloc_c = group_c_reg;
  assign rt.polarity = pol_reg;
  assign rt.flags = status_flags_i;

  osr_router u_router (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .rt (rt.rtr)
  );

  logic [4:0] led_reg, led_next;

  always_comb
  begin
    // bit k of the led row is position k+1 from the right
    led_next = view_sel_i ? rt.contacts : 5'h00;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      led_reg <= 5'h00;
    else
      led_reg <= led_next;
  end

  assign contact_o = rt.contacts;
  assign always_alloc_o = rt.always_alloc;
  assign status_led_o = led_reg;
  assign editing_o = (state_reg == OSR_EDIT);
  assign edit_value_o = edit_reg;
  assign edit_sel_o = sel_reg;
  assign param_rdata_o = rdata_reg;
  assign saved_o = saved_reg;
  assign refused_o = refused_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_save_locked: assert property (
    servo_on_i |=> $stable(group_a_reg) && $stable(group_b_reg)
    && $stable(group_c_reg) && $stable(pol_reg))
    else $error("parameter changed while servo on");
  a_refuse_pulse: assert property (
    state_reg == OSR_EDIT && save_i && servo_on_i && !hold_done
    |=> refused_o && editing_o ##1 !refused_o || $past(save_i))
    else $error("refusal not flagged for one cycle");
  a_hold_discard: assert property (
    state_reg == OSR_EDIT && hold_done
    |=> !editing_o && !saved_o && $stable(group_a_reg) && $stable(pol_reg))
    else $error("mode hold did not discard the edit");
  a_view_leds: assert property (
    view_sel_i |=> status_led_o == $past(rt.contacts))
    else $error("leds do not follow contacts in status view");
  a_view_dark: assert property (
    !view_sel_i |=> status_led_o == 5'h00)
    else $error("leds lit outside status view");
  a_led_position: assert property (
    view_sel_i |=> status_led_o[4] == $past(contact_o[4])
    && status_led_o[0] == $past(contact_o[0]))
    else $error("led positions swapped");
  a_reset_defaults: assert property (
    disable iff (1'b0) $past(sys_rst_i) && !sys_rst_i |-> group_a_reg == 16'h4321
    && group_b_reg == 16'h0005 && group_c_reg == 16'h0000)
    else $error("allocation reset values wrong");

  c_refused: cover property (refused_o);
  c_discard: cover property (state_reg == OSR_EDIT && hold_done);
  c_saved: cover property (saved_o);

endmodule : osr_top

//--- osr_pkg.sv
package osr_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_SIGNALS = 9;
  localparam int NUM_CONTACTS = 5;
  localparam int PARAM_W = 16;

  // ----------------------------------------------------------------
  // parameter selection codes on the loader port
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_GROUP_A = 2'h0;
  localparam logic [1:0] SEL_GROUP_B = 2'h1;
  localparam logic [1:0] SEL_GROUP_C = 2'h2;
  localparam logic [1:0] SEL_POLARITY = 2'h3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] GROUP_A_RESET = 16'h4321;
  localparam logic [15:0] GROUP_B_RESET = 16'h0005;
  localparam logic [15:0] GROUP_C_RESET = 16'h0000;
  localparam logic [15:0] POLARITY_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // allocation digit codes
  // ----------------------------------------------------------------
  localparam logic [3:0] DIGIT_NONE = 4'h0;
  localparam logic [3:0] DIGIT_ALWAYS = 4'hF;

  // ----------------------------------------------------------------
  // status flag bit positions
  // ----------------------------------------------------------------
  localparam int FLAG_FAULT = 0;
  localparam int FLAG_READY = 1;
  localparam int FLAG_ZERO_SPEED = 2;
  localparam int FLAG_BRAKE = 3;
  localparam int FLAG_POSITION_REACHED = 4;
  localparam int FLAG_TORQUE_LIMIT = 5;
  localparam int FLAG_SPEED_LIMIT = 6;
  localparam int FLAG_SPEED_REACHED = 7;
  localparam int FLAG_WARNING = 8;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int MODE_HOLD_MS = 1000;
  localparam int MODE_HOLD_CYCLES = (CLK_HZ / 1000) * MODE_HOLD_MS;
  localparam int HOLD_CNT_W = 26;

  // digit n of a signal: four signals per word, lowest digit first
  function automatic logic [3:0] osr_digit(input logic [15:0] word, input int idx);
    osr_digit = word[(idx % 4) * 4 +: 4];
  endfunction : osr_digit

endpackage : osr_pkg

//--- osr_route_if.sv
`timescale 1ns/1ps
interface osr_route_if;
  logic [15:0] alloc_a;
  logic [15:0] alloc_b;
  logic [15:0] alloc_c;
  logic [15:0] polarity;
  logic [8:0] flags;
  logic [4:0] contacts;
  logic [8:0] always_alloc;

  modport ctrl (
    output alloc_a, alloc_b, alloc_c, polarity, flags,
    input contacts, always_alloc
  );
  modport rtr (
    input alloc_a, alloc_b, alloc_c, polarity, flags,
    output contacts, always_alloc
  );
endinterface : osr_route_if

//--- osr_router.sv
`timescale 1ns/1ps
module osr_router (
  input wire logic ref_clk_i, // system clock
  input wire logic sys_rst_i, // sync reset, active high
  osr_route_if.rtr rt         // allocation in, contacts out
);

  logic [4:0] contacts_reg;
  logic [4:0] contacts_next;
  logic [8:0] always_reg;
  logic [8:0] always_next;
  logic [4:0] raw;
  logic [3:0] d;
  logic [15:0] word;

  // ----------------------------------------------------------------
  // routing
  // ----------------------------------------------------------------
  always_comb
  begin
    raw = 5'h00;
    always_next = 9'h000;
    d = 4'h0;
    word = 16'h0000;
    for (int s = 0; s < osr_pkg::NUM_SIGNALS; s++)
    begin
      word = (s < 4) ? rt.alloc_a : (s < 8) ? rt.alloc_b : rt.alloc_c;
      d = osr_pkg::osr_digit(word, s);
      for (int c = 1; c <= osr_pkg::NUM_CONTACTS; c++)
      begin
        if (d == 4'(c) && rt.flags[s])
          raw[c-1] = 1'b1;
      end
      // always-allocated signals drive no contact of their own
      always_next[s] = (d == osr_pkg::DIGIT_ALWAYS);
    end
    contacts_next = raw ^ rt.polarity[4:0];
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      contacts_reg <= 5'h00;
      always_reg <= 9'h000;
    end
    else
    begin
      contacts_reg <= contacts_next;
      always_reg <= always_next;
    end
  end

  assign rt.contacts = contacts_reg;
  assign rt.always_alloc = always_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_route_first_contact: assert property (
    rt.flags == 9'h001 && rt.alloc_a[3:0] == 4'h1 && !rt.polarity[0]
    |=> contacts_reg == {$past(rt.polarity[4:1]), 1'b1})
    else $error("fault on digit 1 did not reach contact one");
  a_unconnected_digit: assert property (
    rt.flags == 9'h100 && rt.alloc_c[3:0] == 4'h0
    |=> contacts_reg == $past(rt.polarity[4:0]))
    else $error("zero digits still drove a contact");
  a_warning_group_c: assert property (
    rt.flags == 9'h100 && rt.alloc_c[3:0] == 4'h2
    |=> contacts_reg == (5'h02 ^ $past(rt.polarity[4:0])))
    else $error("warning not routed by third word");
  a_idle_polarity: assert property (
    rt.flags == 9'h000 |=> contacts_reg == $past(rt.polarity[4:0]))
    else $error("idle contacts do not follow polarity");
  a_always_flag: assert property (
    rt.alloc_a[3:0] == 4'hF && rt.flags == 9'h001
    |=> always_reg[0] && contacts_reg == $past(rt.polarity[4:0]))
    else $error("always-allocated digit mishandled");
  a_shared_or: assert property (
    rt.alloc_a[7:0] == 8'h11 && (rt.flags[0] || rt.flags[1])
    |=> contacts_reg[0] != $past(rt.polarity[0]))
    else $error("shared contact is not the or of its signals");

  c_shared_contact: cover property (rt.alloc_a[7:0] == 8'h11 && rt.flags[1:0] == 2'h3);
  c_inverted_out: cover property (rt.polarity[0] && contacts_reg[0] == 1'b0);

endmodule : osr_router

//--- osr_load_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// load wired to the output contacts
// ----------------------------------------------------------------
// the load sees a contact as energized when the wire is at its active
// level; an active-low contact is energized while the wire is low
module osr_load_model (
  input wire logic ref_clk_i,         // system clock
  input wire logic [4:0] contact_i,   // contact wires one to five
  input wire logic [4:0] active_low_i, // wiring sense of each contact
  output logic [4:0] energized_o      // load state per contact
);
  logic [4:0] energized_reg;
  logic [4:0] energized_next;

  always_comb
  begin
    energized_next = contact_i ^ active_low_i;
  end

  // registered so a glitch on the wire is not taken as a load change
  always_ff @(posedge ref_clk_i)
  begin
    energized_reg <= energized_next;
  end

  assign energized_o = energized_reg;
endmodule : osr_load_model

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic servo_on_i = 1'b0;
  logic [8:0] status_flags_i = 9'h000;
  logic [1:0] param_sel_i = 2'h0;
  logic edit_open_i = 1'b0;
  logic edit_write_i = 1'b0;
  logic [15:0] edit_data_i = 16'h0000;
  logic save_i = 1'b0;
  logic mode_key_i = 1'b0;
  logic view_sel_i = 1'b1;
  logic [4:0] contact_o;
  logic [4:0] status_led_o;
  logic [8:0] always_alloc_o;
  logic editing_o;
  logic [15:0] edit_value_o;
  logic [1:0] edit_sel_o;
  logic [15:0] param_rdata_o;
  logic saved_o;
  logic refused_o;
  logic [4:0] energized;
  logic [15:0] sh [4];
  logic [15:0] cfg [3][4];
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;

  always #10 ref_clk_i = ~ref_clk_i;

  osr_top #(.HOLD_CYCLES(20)) u_dut (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .servo_on_i(servo_on_i),
    .status_flags_i(status_flags_i), .param_sel_i(param_sel_i),
    .edit_open_i(edit_open_i), .edit_write_i(edit_write_i), .edit_data_i(edit_data_i),
    .save_i(save_i), .mode_key_i(mode_key_i), .view_sel_i(view_sel_i),
    .contact_o(contact_o), .status_led_o(status_led_o), .always_alloc_o(always_alloc_o),
    .editing_o(editing_o), .edit_value_o(edit_value_o), .edit_sel_o(edit_sel_o),
    .param_rdata_o(param_rdata_o), .saved_o(saved_o), .refused_o(refused_o)
  );

  osr_load_model u_load (
    .ref_clk_i(ref_clk_i), .contact_i(contact_o), .active_low_i(sh[3][4:0]),
    .energized_o(energized)
  );

  // ----------------------------------------------------------------
  // verdict
  // ----------------------------------------------------------------
  task automatic final_report();
    if (err_total == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  // run is a few hundred cycles at most
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // compares and expectations
  // ----------------------------------------------------------------
  task automatic cmp_val(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp_val

  task automatic cmp_flag(input string name, input logic exp, input logic got);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask : cmp_flag

  // flags ored per contact, before polarity
  function automatic logic [4:0] route_raw(input logic [8:0] f);
    logic [47:0] w;
    logic [3:0] d;
    w = {sh[2], sh[1], sh[0]};
    route_raw = 5'h00;
    for (int i = 0; i < 9; i++)
    begin
      d = w[i*4 +: 4];
      if (d >= 4'h1 && d <= 4'h5 && f[i])
        route_raw[d - 4'h1] = 1'b1;
    end
  endfunction : route_raw

  function automatic logic [8:0] always_set();
    logic [47:0] w;
    w = {sh[2], sh[1], sh[0]};
    always_set = 9'h000;
    for (int i = 0; i < 9; i++)
      always_set[i] = (w[i*4 +: 4] == 4'hF);
  endfunction : always_set

  // ----------------------------------------------------------------
  // loader port access
  // ----------------------------------------------------------------
  task automatic read_param(input logic [1:0] sel, input logic [15:0] exp);
    @(posedge ref_clk_i) param_sel_i <= sel;
    @(posedge ref_clk_i);
    #1 cmp_val("param_rdata", exp, param_rdata_o);
  endtask : read_param

  // open, write, save; servo_on_i decides accept or refuse
  task automatic edit_param(input logic [1:0] sel, input logic [15:0] data);
    @(posedge ref_clk_i)
    begin
      param_sel_i <= sel;
      edit_open_i <= 1'b1;
    end
    @(posedge ref_clk_i)
    begin
      edit_open_i <= 1'b0;
      edit_write_i <= 1'b1;
      edit_data_i <= data;
    end
    #1 cmp_val("edit_value", sh[sel], edit_value_o);
    @(posedge ref_clk_i)
    begin
      edit_write_i <= 1'b0;
      save_i <= 1'b1;
    end
    @(posedge ref_clk_i) save_i <= 1'b0;
    #1;
    cmp_flag("saved", !servo_on_i, saved_o);
    cmp_flag("refused", servo_on_i, refused_o);
    if (!servo_on_i)
      sh[sel] = data;
  endtask : edit_param

  // flag pattern in, contacts, leds and load state out
  task automatic check_route(input logic [8:0] f);
    logic [4:0] raw;
    @(posedge ref_clk_i) status_flags_i <= f;
    repeat (3) @(posedge ref_clk_i);
    #1 raw = route_raw(f);
    cmp_val("contact", {11'h000, raw ^ sh[3][4:0]}, {11'h000, contact_o});
    cmp_val("led", {11'h000, raw ^ sh[3][4:0]}, {11'h000, status_led_o});
    cmp_val("load", {11'h000, raw}, {11'h000, energized});
    cmp_val("always_alloc", {7'h00, always_set()}, {7'h00, always_alloc_o});
  endtask : check_route

  task automatic route_sweep();
    for (int i = 0; i < 9; i++)
      check_route(9'h001 << i);
    check_route(9'h1FF);
    check_route(9'h000);
  endtask : route_sweep

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    sh[0] = 16'h4321;
    sh[1] = 16'h0005;
    sh[2] = 16'h0000;
    sh[3] = 16'h0000;
    cfg[0] = '{16'h1111, 16'h6F05, 16'h0002, 16'h0015};
    cfg[1] = '{16'h000F, 16'h5432, 16'h000F, 16'h001A};
    cfg[2] = '{16'h4321, 16'h0005, 16'h0000, 16'h0000};
    repeat (16) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    for (int s = 0; s < 4; s++)
      read_param(s[1:0], sh[s]);
    route_sweep();
    for (int c = 0; c < 3; c++)
    begin
      for (int s = 0; s < 4; s++)
        edit_param(s[1:0], cfg[c][s]);
      route_sweep();
    end
    // refused save stays in edit; a long mode press drops the edit
    @(posedge ref_clk_i) servo_on_i <= 1'b1;
    edit_param(osr_pkg::SEL_GROUP_B, 16'h1234);
    cmp_flag("editing", 1'b1, editing_o);
    @(posedge ref_clk_i) mode_key_i <= 1'b1;
    repeat (15) @(posedge ref_clk_i);
    #1 cmp_flag("editing", 1'b1, editing_o);
    // 3 sync stages, 1 level stage, then 20 held cycles: drop after edge 24
    repeat (8) @(posedge ref_clk_i);
    #1 cmp_flag("editing", 1'b1, editing_o);
    @(posedge ref_clk_i);
    #1 cmp_flag("editing", 1'b0, editing_o);
    @(posedge ref_clk_i) mode_key_i <= 1'b0;
    read_param(osr_pkg::SEL_GROUP_B, sh[1]);
    @(posedge ref_clk_i) servo_on_i <= 1'b0;
    check_route(9'h010);
    // view deselected leaves the leds dark
    @(posedge ref_clk_i) view_sel_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1 cmp_val("led", 16'h0000, {11'h000, status_led_o});
    final_report();
  end
endmodule : testbench
